// File: hdl/adcso_map.svh
// Timing counts and field layouts of the serial output port
`ifndef ADCSO_MAP_SVH
`define ADCSO_MAP_SVH

`define ADCSO_CLK_HZ        50000000
`define ADCSO_MOD_HZ        12500000
`define ADCSO_MOD_DIV       (`ADCSO_CLK_HZ / `ADCSO_MOD_HZ)
`define ADCSO_PH_FULL       (`ADCSO_MOD_DIV)
`define ADCSO_PH_HALF       (`ADCSO_MOD_DIV / 2)
`define ADCSO_CNT_W         4
`define ADCSO_DATA_W        24
`define ADCSO_STAT_W        8
`define ADCSO_FRAME_BITS    32
`define ADCSO_LAST_BIT      6'h1f
`define ADCSO_SDL_FIRST     6'h10
`define ADCSO_SDL_SECOND    6'h20
`define ADCSO_WR_ADDR_W     16
`define ADCSO_WR_DATA_W     16
`define ADCSO_STAT_RST      8'h00

`endif

// File: hdl/adcso_pkg.sv
// Types shared by the serial output port modules
`include "adcso_map.svh"

package adcso_pkg;

    typedef enum logic [1:0] {
        FR_IDLE,
        FR_READY,
        FR_SHIFT,
        FR_TAIL
    } adcso_frame_t;

    typedef struct packed {
        logic [`ADCSO_STAT_W-1:0] status;
        logic [`ADCSO_DATA_W-1:0] data;
    } adcso_word_t;

    typedef struct packed {
        logic [`ADCSO_WR_ADDR_W-1:0] addr;
        logic [`ADCSO_WR_DATA_W-1:0] data;
    } adcso_wr_t;

endpackage

// File: hdl/adcso_skid.sv
// Two-entry buffer between the sample source and the serialiser
`timescale 1ns/100ps
`include "adcso_map.svh"

module adcso_skid
(
    // Clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    // Fill side
    input  wire logic                i_valid,
    input  wire adcso_pkg::adcso_word_t i_word,
    output logic                     o_ready,
    // Drain side
    output logic                     o_valid,
    output adcso_pkg::adcso_word_t   o_word,
    input  wire logic                i_ready
);

    adcso_pkg::adcso_word_t mem_ff [2];
    logic                   wr_ptr_ff;
    logic                   rd_ptr_ff;
    logic [1:0]             count_ff;

    // Valid while ready is low is refused, so a held word is never stored twice
    wire push = i_valid && o_ready;
    wire pop  = i_ready && (count_ff != 2'h0);
    wire [1:0] nxt_count = count_ff + {1'b0, push} - {1'b0, pop};

    assign o_valid = (count_ff != 2'h0);
    assign o_word  = mem_ff[rd_ptr_ff];

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            count_ff  <= 2'h0;
            o_ready   <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr_ff <= ~wr_ptr_ff;
            if (pop)
                rd_ptr_ff <= ~rd_ptr_ff;
            count_ff <= nxt_count;
            // Registered ready: full means the source must wait
            o_ready  <= (nxt_count != 2'h2);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (push)
            mem_ff[wr_ptr_ff] <= i_word;
    end

endmodule

// File: hdl/adcso_clkgen.sv
// Modulator clock and serial clock generator
`timescale 1ns/100ps
`include "adcso_map.svh"

module adcso_clkgen
(
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // Configuration
    input  wire logic i_half_phase,
    input  wire logic i_polarity,
    // Clocks out
    output logic      o_mod_clk,
    output logic      o_sco,
    // Internal edge events, in the same cycle as the pin edge
    output logic      o_rise,
    output logic      o_fall
);

    localparam logic [`ADCSO_CNT_W-1:0] MOD_HALF = `ADCSO_CNT_W'(`ADCSO_MOD_DIV / 2 - 1);
    localparam logic [`ADCSO_CNT_W-1:0] PH_FULL  = `ADCSO_CNT_W'(`ADCSO_PH_FULL - 1);
    localparam logic [`ADCSO_CNT_W-1:0] PH_HALF  = `ADCSO_CNT_W'(`ADCSO_PH_HALF - 1);

    logic [`ADCSO_CNT_W-1:0] mod_cnt_ff;
    logic [`ADCSO_CNT_W-1:0] ph_cnt_ff;
    logic                    sco_int_ff;

    wire [`ADCSO_CNT_W-1:0] ph_last = i_half_phase ? PH_HALF : PH_FULL;
    wire                    mod_wrap = (mod_cnt_ff >= MOD_HALF);
    wire                    ph_wrap  = (ph_cnt_ff >= ph_last);
    wire                    nxt_sco  = ph_wrap ? ~sco_int_ff : sco_int_ff;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            mod_cnt_ff <= '0;
            ph_cnt_ff  <= '0;
            sco_int_ff <= 1'b0;
            o_mod_clk  <= 1'b0;
            o_sco      <= 1'b0;
            o_rise     <= 1'b0;
            o_fall     <= 1'b0;
        end
        else
        begin
            // Modulator clock is I_CLK divided down
            mod_cnt_ff <= mod_wrap ? '0 : mod_cnt_ff + 1'b1;
            if (mod_wrap)
                o_mod_clk <= ~o_mod_clk;
            // Each serial clock phase is one or half a modulator period
            ph_cnt_ff  <= ph_wrap ? '0 : ph_cnt_ff + 1'b1;
            sco_int_ff <= nxt_sco;
            // Polarity only inverts the pin, events keep their meaning
            o_sco      <= nxt_sco ^ i_polarity;
            o_rise     <= ph_wrap && !sco_int_ff;
            o_fall     <= ph_wrap && sco_int_ff;
        end
    end

endmodule

// File: hdl/adcso_top.sv
// Serial output and register write port of the converter
// Functional notes
// - Modulator clock is derived from the master clock, within its legal range.
// - Serial clock phases last one or half a modulator period, pin selected.
// - Data ready goes low after a rising edge for exactly one serial period.
// - Frame sync low after rising edge for 32 bits, high after the last bit's falling edge.
// - Serial data changes after rising edge, stable through the next falling edge.
// - Bus share strobe first falls 16 periods after data ready returns high.
// - Bus share strobe pulses twice per frame, 16 serial clock periods apart.
// - Polarity select one inverts every serial clock edge relationship.
// - In decimate-by-32, frame sync only pulses for divide 0, rate 1.
// - Serial data output released before the rising edge another device uses.
`timescale 1ns/100ps
`include "adcso_map.svh"

module adcso_top
(
    // Clock and reset
    input  wire logic                           I_CLK,
    input  wire logic                           I_SYS_RST,
    // Configuration pins
    input  wire logic                           i_CLOCK_RATE_SELECT,
    input  wire logic                           i_CLOCK_DIVIDE_SELECT,
    input  wire logic                           i_CLOCK_POLARITY_SELECT,
    input  wire logic                           i_DECIM32_MODE,
    // Sample stream in
    input  wire logic                           i_SAMPLE_VALID,
    input  wire adcso_pkg::adcso_word_t         i_SAMPLE,
    output logic                                o_SAMPLE_READY,
    // Serial read port
    output logic                                o_MODULATOR_CLOCK,
    output logic                                o_SERIAL_CLOCK,
    output logic                                o_DATA_READY_N,
    output logic                                o_FRAME_SYNC_OUT,
    output logic                                o_SERIAL_DATA_OUT,
    output logic                                o_SERIAL_DATA_OUT_OE,
    output logic                                o_BUS_SHARE_STROBE,
    // Serial write port
    input  wire logic                           i_SERIAL_DATA_IN,
    input  wire logic                           i_FRAME_SYNC_IN,
    output adcso_pkg::adcso_wr_t                o_REG_WRITE,
    output logic                                o_REG_WRITE_STB
);

    // Strobe slots fall on multiples of 16 periods after data ready rises
    function automatic logic sdl_slot(input logic [5:0] pc);
        sdl_slot = (pc == `ADCSO_SDL_FIRST) || (pc == `ADCSO_SDL_SECOND);
    endfunction

    logic                   rise;
    logic                   fall;
    logic                   buf_valid;
    logic                   buf_pop;
    adcso_pkg::adcso_word_t buf_word;

    adcso_pkg::adcso_frame_t               state_ff;
    logic [5:0]                            pc_ff;
    logic [`ADCSO_FRAME_BITS-1:0]          shift_ff;
    logic [`ADCSO_FRAME_BITS-1:0]          rx_ff;
    logic [5:0]                            rx_cnt_ff;
    logic                                  rx_busy_ff;

    // Fast serial clock only for divide 0 and rate 1
    wire half_phase = i_CLOCK_RATE_SELECT && !i_CLOCK_DIVIDE_SELECT;
    // Frame sync is stuck low in decimate-by-32 unless the fast combination is set
    wire fso_stuck  = i_DECIM32_MODE && !half_phase;
    wire [5:0] nxt_pc = pc_ff + 6'h01;
    wire start      = rise && (state_ff == adcso_pkg::FR_IDLE) && buf_valid;
    wire last_fall  = fall && (state_ff == adcso_pkg::FR_SHIFT) && (pc_ff == `ADCSO_LAST_BIT);
    wire rx_start   = fall && !rx_busy_ff && !i_FRAME_SYNC_IN;
    wire rx_done    = fall && rx_busy_ff && (rx_cnt_ff == `ADCSO_LAST_BIT);

    assign buf_pop = start;

    adcso_clkgen u_clkgen
    (
        .i_clk        (I_CLK),
        .i_rst        (I_SYS_RST),
        .i_half_phase (half_phase),
        .i_polarity   (i_CLOCK_POLARITY_SELECT),
        .o_mod_clk    (o_MODULATOR_CLOCK),
        .o_sco        (o_SERIAL_CLOCK),
        .o_rise       (rise),
        .o_fall       (fall)
    );

    // Buffer lets a stalled frame hold off the source without loss
    adcso_skid u_skid
    (
        .i_clk   (I_CLK),
        .i_rst   (I_SYS_RST),
        .i_valid (i_SAMPLE_VALID),
        .i_word  (i_SAMPLE),
        .o_ready (o_SAMPLE_READY),
        .o_valid (buf_valid),
        .o_word  (buf_word),
        .i_ready (buf_pop)
    );

    // Read frame sequencer
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            state_ff             <= adcso_pkg::FR_IDLE;
            pc_ff                <= 6'h00;
            shift_ff             <= '0;
            o_DATA_READY_N       <= 1'b1;
            o_FRAME_SYNC_OUT     <= 1'b1;
            o_SERIAL_DATA_OUT    <= 1'b0;
            o_SERIAL_DATA_OUT_OE <= 1'b0;
            o_BUS_SHARE_STROBE   <= 1'b1;
        end
        else
        begin
            unique case (state_ff)
                adcso_pkg::FR_IDLE:
                begin
                    if (fso_stuck)
                        o_FRAME_SYNC_OUT <= 1'b0;
                    else
                        o_FRAME_SYNC_OUT <= 1'b1;
                    if (start)
                    begin
                        shift_ff       <= buf_word;
                        o_DATA_READY_N <= 1'b0;
                        state_ff       <= adcso_pkg::FR_READY;
                    end
                end
                adcso_pkg::FR_READY:
                begin
                    if (rise)
                    begin
                        // One full period later data ready returns high
                        o_DATA_READY_N       <= 1'b1;
                        o_FRAME_SYNC_OUT     <= 1'b0;
                        o_SERIAL_DATA_OUT    <= shift_ff[`ADCSO_FRAME_BITS-1];
                        o_SERIAL_DATA_OUT_OE <= 1'b1;
                        shift_ff             <= {shift_ff[`ADCSO_FRAME_BITS-2:0], 1'b0};
                        pc_ff                <= 6'h00;
                        state_ff             <= adcso_pkg::FR_SHIFT;
                    end
                end
                adcso_pkg::FR_SHIFT:
                begin
                    if (rise)
                    begin
                        pc_ff              <= nxt_pc;
                        // Data moves only on rising events, so it holds across fall
                        o_SERIAL_DATA_OUT  <= shift_ff[`ADCSO_FRAME_BITS-1];
                        shift_ff           <= {shift_ff[`ADCSO_FRAME_BITS-2:0], 1'b0};
                        o_BUS_SHARE_STROBE <= !sdl_slot(nxt_pc);
                    end
                    else if (last_fall)
                    begin
                        // Released half a period before the next rising edge
                        o_SERIAL_DATA_OUT_OE <= 1'b0;
                        o_SERIAL_DATA_OUT    <= 1'b0;
                        o_FRAME_SYNC_OUT     <= fso_stuck ? 1'b0 : 1'b1;
                        state_ff             <= adcso_pkg::FR_TAIL;
                    end
                end
                adcso_pkg::FR_TAIL:
                begin
                    if (rise)
                    begin
                        pc_ff              <= nxt_pc;
                        o_BUS_SHARE_STROBE <= !sdl_slot(nxt_pc);
                        if (pc_ff == `ADCSO_SDL_SECOND)
                            state_ff <= adcso_pkg::FR_IDLE;
                    end
                end
            endcase
        end
    end

    // Register write receiver, sampled on serial clock falling events
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            rx_ff           <= '0;
            rx_cnt_ff       <= 6'h00;
            rx_busy_ff      <= 1'b0;
            o_REG_WRITE     <= '0;
            o_REG_WRITE_STB <= 1'b0;
        end
        else
        begin
            o_REG_WRITE_STB <= 1'b0;
            if (rx_start)
            begin
                // Frame sync low at a falling event opens the word
                rx_ff      <= {rx_ff[`ADCSO_FRAME_BITS-2:0], i_SERIAL_DATA_IN};
                rx_cnt_ff  <= 6'h01;
                rx_busy_ff <= 1'b1;
            end
            else if (fall && rx_busy_ff)
            begin
                rx_ff     <= {rx_ff[`ADCSO_FRAME_BITS-2:0], i_SERIAL_DATA_IN};
                rx_cnt_ff <= rx_cnt_ff + 6'h01;
                if (rx_done)
                begin
                    rx_busy_ff      <= 1'b0;
                    o_REG_WRITE     <= {rx_ff[`ADCSO_FRAME_BITS-2:0], i_SERIAL_DATA_IN};
                    o_REG_WRITE_STB <= 1'b1;
                end
            end
        end
    end

endmodule

// File: testbench/adcso_tb_chk.sv
// Timing checker for the serial output port
`timescale 1ns/100ps
module adcso_chk
(
    // Clock, reset, pins
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic i_CLOCK_RATE_SELECT,
    input wire logic i_CLOCK_DIVIDE_SELECT,
    input wire logic i_CLOCK_POLARITY_SELECT,
    input wire logic i_DECIM32_MODE,
    // Watched outputs
    input wire logic o_MODULATOR_CLOCK,
    input wire logic o_SERIAL_CLOCK,
    input wire logic o_DATA_READY_N,
    input wire logic o_FRAME_SYNC_OUT,
    input wire logic o_SERIAL_DATA_OUT,
    input wire logic o_SERIAL_DATA_OUT_OE,
    input wire logic o_BUS_SHARE_STROBE,
    input wire logic o_REG_WRITE_STB
);
    logic       sco_q;
    logic [5:0] dr_lo;
    logic [5:0] sl_lo;
    logic [9:0] gap;
    logic [9:0] sgap;
    wire        sco_i   = o_SERIAL_CLOCK ^ i_CLOCK_POLARITY_SELECT;
    wire        rise_ev = sco_i & ~sco_q;
    wire        fall_ev = ~sco_i & sco_q;
    wire        full    = i_CLOCK_DIVIDE_SELECT | ~i_CLOCK_RATE_SELECT;
    wire        fs_on   = ~(i_DECIM32_MODE & full);
    wire  [5:0] per     = full ? 6'h08 : 6'h04;
    wire  [9:0] p16     = {per, 4'h0};
    wire  [9:0] p32     = {per[4:0], 5'h00};

    // Counters span a whole frame, too long for a repetition
    always_ff @(posedge I_CLK)
    begin
        sco_q <= sco_i;
        dr_lo <= o_DATA_READY_N ? 6'h00 : dr_lo + 6'h01;
        sl_lo <= o_BUS_SHARE_STROBE ? 6'h00 : sl_lo + 6'h01;
        gap   <= $rose(o_DATA_READY_N) ? 10'h001 : gap + 10'h001;
        sgap  <= $fell(o_BUS_SHARE_STROBE) ? 10'h001 : sgap + 10'h001;
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);

    mod_clk_a:
        assert property ($rose(o_MODULATOR_CLOCK) |=> o_MODULATOR_CLOCK ##1
            !o_MODULATOR_CLOCK [*2] ##1 o_MODULATOR_CLOCK) else $error("mod clock shape");
    sco_full_a:
        assert property ($rose(sco_i) && full |=> sco_i [*3] ##1 !sco_i [*4] ##1 sco_i)
        else $error("full phase length");
    sco_half_a:
        assert property ($rose(sco_i) && !full |=> sco_i ##1 !sco_i [*2] ##1 sco_i)
        else $error("half phase length");
    data_ready_n_width_a:
        assert property ($rose(o_DATA_READY_N) |-> dr_lo == per && $past(rise_ev))
        else $error("data ready width");
    fso_start_a:
        assert property (fs_on && $fell(o_FRAME_SYNC_OUT) |-> $past(rise_ev)
            && $rose(o_DATA_READY_N)) else $error("frame sync start");
    fso_end_a:
        assert property ($rose(o_FRAME_SYNC_OUT) |-> $past(fall_ev)
            && $fell(o_SERIAL_DATA_OUT_OE)) else $error("frame sync end");
    sdo_change_a:
        assert property (o_SERIAL_DATA_OUT_OE && $past(o_SERIAL_DATA_OUT_OE)
            && $changed(o_SERIAL_DATA_OUT) |-> $past(rise_ev)) else $error("data edge");
    sdl_delay_a:
        assert property ($fell(o_BUS_SHARE_STROBE) |-> gap == p16 || gap == p32)
        else $error("share strobe delay");
    sdl_width_a:
        assert property ($rose(o_BUS_SHARE_STROBE) |-> sl_lo == per)
        else $error("share strobe width");
    sdl_repeat_a:
        assert property ($fell(o_BUS_SHARE_STROBE) && gap == p32 |-> sgap == p16)
        else $error("share strobe spacing");
    oe_release_a:
        assert property ($fell(o_SERIAL_DATA_OUT_OE) |-> $past(fall_ev) && !o_SERIAL_DATA_OUT)
        else $error("data release");
    fso_stuck_a:
        assert property (!fs_on ##1 !fs_on |=> !o_FRAME_SYNC_OUT)
        else $error("frame sync not held low");

    cover property (!full && $fell(o_DATA_READY_N));
    cover property (!fs_on && $fell(o_SERIAL_DATA_OUT_OE));
    cover property ($rose(o_REG_WRITE_STB));
endmodule

// File: testbench/adcso_host.sv
// Host serial port model: reads frames, sends register writes
`timescale 1ns/100ps
module adcso_host
(
    // Link from the device
    input  wire logic i_clk,
    input  wire logic i_sco,
    input  wire logic i_pol,
    input  wire logic i_sdo,
    input  wire logic i_oe,
    // Write link to the device
    output logic      o_sdi,
    output logic      o_fsi
);
    logic        sco_q = 1'b0;
    logic [31:0] sh;
    int          nb = 0;
    logic [31:0] rx_q[$];
    wire         sco_i = i_sco ^ i_pol;

    initial
    begin
        o_sdi = 1'b0;
        o_fsi = 1'b1;
    end

    // Sampled on the internal falling edge, only while driven
    always @(posedge i_clk)
    begin
        sco_q <= sco_i;
        if (sco_q && !sco_i && i_oe)
        begin
            sh = {sh[30:0], i_sdo};
            nb = nb + 1;
            if (nb == 32)
            begin
                rx_q.push_back(sh);
                nb = 0;
            end
        end
    end

    // Idle data line flips so a stale bit never looks valid
    task send(input logic [31:0] w);
        for (int i = 31; i >= -1; i--)
        begin
            @(posedge i_clk iff (sco_i && !sco_q));
            @(negedge i_clk);
            o_fsi = (i != 31);
            o_sdi = (i >= 0) ? w[i] : ~o_sdi;
        end
    endtask
endmodule

// File: testbench/tb_top.sv
// Testbench for the serial output port
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb_top;
    logic                   clk, rst, rate, div, pol, dec, vld, serial_data_in, frame_sync_in, rdy;
    logic                   mclk, sco, data_ready_n, frame_sync_out, serial_data_out, oe, bus_share_strobe, stb, seen_full;
    logic                   fso_lo, fso_hi;
    logic [31:0]            got;
    adcso_pkg::adcso_word_t smp;
    adcso_pkg::adcso_wr_t   wr;
    int                     fails = 0;
    int                     cmp_count = 0;
    logic [31:0]            words[4] = '{32'h80000001, 32'h7ffffffe, 32'h01234567, 32'hfedcba98};

    adcso_top dut_u (.I_CLK(clk), .I_SYS_RST(rst), .i_CLOCK_RATE_SELECT(rate),
        .i_CLOCK_DIVIDE_SELECT(div), .i_CLOCK_POLARITY_SELECT(pol), .i_DECIM32_MODE(dec),
        .i_SAMPLE_VALID(vld), .i_SAMPLE(smp), .o_SAMPLE_READY(rdy), .o_MODULATOR_CLOCK(mclk),
        .o_SERIAL_CLOCK(sco), .o_DATA_READY_N(data_ready_n), .o_FRAME_SYNC_OUT(frame_sync_out),
        .o_SERIAL_DATA_OUT(serial_data_out), .o_SERIAL_DATA_OUT_OE(oe), .o_BUS_SHARE_STROBE(bus_share_strobe),
        .i_SERIAL_DATA_IN(serial_data_in), .i_FRAME_SYNC_IN(frame_sync_in), .o_REG_WRITE(wr), .o_REG_WRITE_STB(stb));
    adcso_host host_u (.i_clk(clk), .i_sco(sco), .i_pol(pol), .i_sdo(serial_data_out), .i_oe(oe),
        .o_sdi(serial_data_in), .o_fsi(frame_sync_in));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (frame_sync_out === 1'b0) fso_lo = 1'b1;
        if (frame_sync_out === 1'b1) fso_hi = 1'b1;
    end

    task final_report;
        $display("fails %0d compares %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task reset_cfg(input logic [3:0] c);
        @(negedge clk);
        {div, rate, pol, dec} = c;
        rst = 1'b1;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        fso_lo = 1'b0;
        fso_hi = 1'b0;
    endtask

    // Holds valid until the buffer takes the word
    task push(input logic [31:0] w);
        int n;
        n = 0;
        @(negedge clk);
        vld = 1'b1;
        smp = w;
        @(posedge clk);
        while (rdy !== 1'b1 && n < 3000)
        begin
            seen_full = 1'b1;
            n++;
            @(posedge clk);
        end
        `CHK(rdy, 1'b1)
    endtask

    task frames(input int n);
        int k;
        for (k = 0; k < n; k++)
            push(words[k]);
        @(negedge clk);
        vld = 1'b0;
        for (k = 0; k < 20000 && host_u.rx_q.size() < n; k++)
            @(negedge clk);
        for (k = 0; k < n; k++)
        begin
            got = (host_u.rx_q.size() > 0) ? host_u.rx_q.pop_front() : 32'hxxxxxxxx;
            `CHK(got, words[k])
        end
    endtask

    task t_stream;
        reset_cfg(4'h8);
        seen_full = 1'b0;
        frames(4);
        `CHK(seen_full, 1'b1)
        `CHK(fso_lo, 1'b1)
        `CHK(frame_sync_out, 1'b1)
    endtask

    task t_half_pol;
        reset_cfg(4'h7);
        frames(2);
        `CHK(fso_lo, 1'b1)
        `CHK(oe, 1'b0)
    endtask

    task t_stuck;
        reset_cfg(4'h9);
        frames(1);
        `CHK(fso_hi, 1'b0)
    endtask

    task t_write(input logic [31:0] w);
        int n;
        fork
            host_u.send(w);
            for (n = 0; n < 2000 && stb !== 1'b1; n++)
                @(posedge clk);
        join
        `CHK(n < 2000, 1'b1)
        `CHK(wr, w)
    endtask

    initial
    begin
        // Reset stands from time zero so no state starts unknown
        {rst, rate, div, pol, dec, vld} = 6'h20;
        smp = 32'h00000000;
        t_stream();
        t_half_pol();
        t_write(32'h8001c3a5);
        t_write(32'h7ffe3c5a);
        t_stuck();
        final_report();
    end

    initial
    begin
        #400000;
        fails++;
        final_report();
    end
endmodule

bind adcso_top adcso_chk chk_u
(
    .I_CLK                   (I_CLK),
    .I_SYS_RST               (I_SYS_RST),
    .i_CLOCK_RATE_SELECT     (i_CLOCK_RATE_SELECT),
    .i_CLOCK_DIVIDE_SELECT   (i_CLOCK_DIVIDE_SELECT),
    .i_CLOCK_POLARITY_SELECT (i_CLOCK_POLARITY_SELECT),
    .i_DECIM32_MODE          (i_DECIM32_MODE),
    .o_MODULATOR_CLOCK       (o_MODULATOR_CLOCK),
    .o_SERIAL_CLOCK          (o_SERIAL_CLOCK),
    .o_DATA_READY_N          (o_DATA_READY_N),
    .o_FRAME_SYNC_OUT        (o_FRAME_SYNC_OUT),
    .o_SERIAL_DATA_OUT       (o_SERIAL_DATA_OUT),
    .o_SERIAL_DATA_OUT_OE    (o_SERIAL_DATA_OUT_OE),
    .o_BUS_SHARE_STROBE      (o_BUS_SHARE_STROBE),
    .o_REG_WRITE_STB         (o_REG_WRITE_STB)
);
